// ### rtl/ocgc_top.sv
// output routing, gating, disable and power control for twelve clock drivers
// Functional notes
// - any divider routes to any output
// - each output differential or single-ended
// - global disable pin high disables all
// - per-output disable bit overrides global enable
// - optional output disable during lock loss
// - crystal loss disables outputs unless overridden
// - disabled output holds per-output static level
// - synchronous gating changes at period end
// - asynchronous gating disables at once
// - dividers reset during power-up initialisation
// - reset pin or bit re-runs divider reset
// - power-down keeps config, stops clocks
// - power-down stops after complete period
// - power-down release restarts glitch-free on sync-gated outputs; other outputs wait for the period end in the first cycle only
// - single-ended pins in phase, polarity invertible
// - drive codes 1..3, code 1 barred low
// - unused drivers individually powered down
// - defaults loaded from store before clocks
// - store takes two writes, newest only
// - select pin picks serial protocol
// - three-wire bit shares data line
// - lock loss flags loop out of sync
// - crystal loss alarm flags bad reference
`timescale 1ns/1ps
`include "ocgc_consts.svh"

module ocgc_top
(
    input  wire logic                                     ref_clk,
    input  wire logic                                     rst_n,
    input  wire logic                                     clk_en,
    input  wire logic                                     global_output_disable_pin,
    input  wire logic                                     power_down_pin_n,
    input  wire logic                                     device_reset_pin_n,
    input  wire logic                                     lock_loss,
    input  wire logic                                     crystal_ref_loss_alarm,
    input  wire logic                                     i2c_select_pin,
    input  wire logic                                     three_wire_select,
    input  wire logic                                     cfg_soft_reset,
    input  wire logic [`OCGC_NUM_DIV*`OCGC_DIV_W-1:0]     cfg_div_half,
    input  wire logic [`OCGC_NUM_OUT*`OCGC_SEL_W-1:0]     cfg_out_src,
    input  wire logic [`OCGC_NUM_OUT-1:0]                 cfg_single_ended,
    input  wire logic [`OCGC_NUM_OUT-1:0]                 cfg_inv_true,
    input  wire logic [`OCGC_NUM_OUT-1:0]                 cfg_inv_comp,
    input  wire logic [`OCGC_NUM_OUT*`OCGC_DRV_W-1:0]     cfg_drive_select,
    input  wire logic [`OCGC_NUM_OUT-1:0]                 cfg_vddo_low,
    input  wire logic [`OCGC_NUM_OUT-1:0]                 cfg_sync_gate,
    input  wire logic [`OCGC_NUM_OUT-1:0]                 cfg_driver_pd,
    input  wire logic                                     cfg_lol_disable,
    input  wire logic                                     cfg_xtal_keep_on,
    input  wire logic                                     cfg_wr,
    input  wire logic [`OCGC_NUM_OUT-1:0]                 cfg_out_disable,
    input  wire logic [`OCGC_NUM_OUT-1:0]                 cfg_disable_high,
    input  wire logic                                     store_program,
    output logic      [`OCGC_NUM_OUT-1:0]                 output_true_pin,
    output logic      [`OCGC_NUM_OUT-1:0]                 output_comp_pin,
    output logic      [`OCGC_NUM_OUT*`OCGC_DRV_W-1:0]     single_ended_drive_select,
    output logic      [`OCGC_NUM_OUT-1:0]                 driver_power_down,
    output logic      [`OCGC_NUM_OUT-1:0]                 out_enabled,
    output logic      [`OCGC_NUM_OUT-1:0]                 out_disable_r_q,
    output logic      [`OCGC_NUM_OUT-1:0]                 disable_high_q,
    output logic                                          init_done,
    output logic      [1:0]                               store_write_count,
    output logic                                          serial_is_i2c,
    output logic                                          spi_shared_data
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 6;

    logic [NSYNC-1:0] pin_raw;    // asynchronous pins gathered
    logic [NSYNC-1:0] pin_m_r;    // first stage, read only by second
    logic [NSYNC-1:0] pin_s_r;    // second stage, safe to use

    assign pin_raw = {i2c_select_pin, crystal_ref_loss_alarm, lock_loss,
                      device_reset_pin_n, power_down_pin_n, global_output_disable_pin};

    // two flops per pin; reset values mean "not disabling, not in reset", except lock loss, which resets high (out of lock)
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_m_r <= 6'h0e;
            pin_s_r <= 6'h0e;
        end
        else if (clk_en)
        begin
            pin_m_r <= pin_raw;
            pin_s_r <= pin_m_r;
        end
    end

    logic oe_dis_s;     // global disable pin, high disables
    logic pd_s;         // power-down active
    logic rst_pin_s;    // reset pin active
    logic lol_s;        // loop out of lock
    logic xlos_s;       // crystal reference alarm
    logic i2c_s;        // interface select level

    assign oe_dis_s  = pin_s_r[0];
    assign pd_s      = ~pin_s_r[1];
    assign rst_pin_s = ~pin_s_r[2];
    assign lol_s     = pin_s_r[3];
    assign xlos_s    = pin_s_r[4];
    assign i2c_s     = pin_s_r[5];

    // ------------------------------------------------------------
    // serial interface selection
    // ------------------------------------------------------------
    // the protocol engine itself lives elsewhere; this only steers it
    assign serial_is_i2c   = i2c_s;
    assign spi_shared_data = ~i2c_s & three_wire_select;

    // ------------------------------------------------------------
    // initialisation sequencer
    // ------------------------------------------------------------
    ocgc_pkg::ocgc_state_t   state_r;    // init or run
    logic [`OCGC_CNT_W-1:0]  init_cnt_r; // cycles spent in init
    logic                    reinit;     // any reset request

    // reset pin and reset bit both restart the sequence
    assign reinit = rst_pin_s | cfg_soft_reset;

    // init holds dividers in reset for a fixed time, then runs
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r    <= ocgc_pkg::OCGC_ST_INIT;
            init_cnt_r <= 4'h0;
        end
        else if (clk_en)
        begin
            if (reinit)
            begin
                state_r    <= ocgc_pkg::OCGC_ST_INIT;
                init_cnt_r <= 4'h0;
            end
            else
            begin
                unique case (state_r)
                    ocgc_pkg::OCGC_ST_INIT:
                    begin
                        // count out the init window
                        if (init_cnt_r == 4'(`OCGC_INIT_CYC - 1))
                            state_r <= ocgc_pkg::OCGC_ST_RUN;
                        else
                            init_cnt_r <= init_cnt_r + 4'h1;
                    end
                    ocgc_pkg::OCGC_ST_RUN:
                    begin
                        init_cnt_r <= 4'h0;
                    end
                endcase
            end
        end
    end

    logic running;   // dividers free to count
    assign running   = (state_r == ocgc_pkg::OCGC_ST_RUN);
    assign init_done = running;

    // ------------------------------------------------------------
    // configuration store and working registers
    // ------------------------------------------------------------
    logic [`OCGC_STORE_W-1:0] store_img_r;  // retained default image
    logic [1:0]               store_cnt_r;  // writes used so far

    // only one image is kept, so programming replaces the old one
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            store_img_r <= `OCGC_STORE_DEF;
            store_cnt_r <= 2'h0;
        end
        else if (clk_en && store_program && running && store_cnt_r != `OCGC_STORE_MAX)
        begin
            store_img_r <= {disable_high_q, out_disable_r_q};
            store_cnt_r <= store_cnt_r + 2'h1;
        end
    end

    assign store_write_count = store_cnt_r;

    // working copy: loaded from store during init, then host-writable;
    // power-down leaves it untouched so configuration survives
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_disable_r_q <= 12'h000;
            disable_high_q  <= 12'h000;
        end
        else if (clk_en)
        begin
            if (!running)
            begin
                out_disable_r_q <= store_img_r[11:0];
                disable_high_q  <= store_img_r[23:12];
            end
            else if (cfg_wr)
            begin
                out_disable_r_q <= cfg_out_disable;
                disable_high_q  <= cfg_disable_high;
            end
        end
    end

    // ------------------------------------------------------------
    // output dividers
    // ------------------------------------------------------------
    logic [`OCGC_NUM_DIV-1:0] div_clk_r;  // divided clocks
    logic [`OCGC_NUM_DIV-1:0] div_end;    // last cycle of a period

    genvar d;
    generate
        for (d = 0; d < `OCGC_NUM_DIV; d = d + 1)
        begin : g_div
            logic [`OCGC_DIV_W-1:0] cnt_r;  // half-period counter
            logic [`OCGC_DIV_W-1:0] half;   // half period minus one

            assign half       = cfg_div_half[d*`OCGC_DIV_W +: `OCGC_DIV_W];
            assign div_end[d] = running & div_clk_r[d] & (cnt_r == half);

            // held at zero through init so all phases line up
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    cnt_r        <= 8'h00;
                    div_clk_r[d] <= 1'b0;
                end
                else if (clk_en)
                begin
                    if (!running)
                    begin
                        cnt_r        <= 8'h00;
                        div_clk_r[d] <= 1'b0;
                    end
                    else if (cnt_r == half)
                    begin
                        cnt_r        <= 8'h00;
                        div_clk_r[d] <= ~div_clk_r[d];
                    end
                    else
                        cnt_r <= cnt_r + 8'h01;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // per-output gating and pin drive
    // ------------------------------------------------------------
    logic pd_prev_r;   // power-down seen last cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pd_prev_r <= 1'b0;
        else if (clk_en)
            pd_prev_r <= pd_s;
    end

    // power-down, and the first cycle after its release, force period-aligned gating
    logic pd_any;
    assign pd_any = pd_s | pd_prev_r;

    // shared disable terms
    logic glob_off;
    assign glob_off = oe_dis_s
                    | (cfg_lol_disable & lol_s)
                    | (~cfg_xtal_keep_on & xlos_s)
                    | ~running;

    genvar o;
    generate
        for (o = 0; o < `OCGC_NUM_OUT; o = o + 1)
        begin : g_out
            logic [`OCGC_SEL_W-1:0] src;    // selected divider
            logic [`OCGC_DRV_W-1:0] drv;    // requested drive code
            logic                   clk_o;  // routed clock
            logic                   bound;  // period end of routed clock
            logic                   want;   // enable wanted now
            logic                   en_r;   // gated enable
            logic                   lvl;    // level before polarity

            assign src   = cfg_out_src[o*`OCGC_SEL_W +: `OCGC_SEL_W];
            assign clk_o = div_clk_r[src];
            assign bound = div_end[src];
            assign want  = ~glob_off & ~out_disable_r_q[o] & ~pd_s;

            // sync mode, power-down, and the first cycle after its release wait for the period end;
            // otherwise the enable follows at once and may clip a pulse
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    en_r <= 1'b0;
                else if (clk_en)
                begin
                    if (!running)
                        en_r <= 1'b0;
                    else if (cfg_sync_gate[o] || pd_any)
                    begin
                        if (bound || !clk_o)
                            en_r <= want;
                    end
                    else
                        en_r <= want;
                end
            end

            assign lvl = en_r ? clk_o : disable_high_q[o];

            // differential: complement inverted; single-ended: in phase
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    output_true_pin[o] <= 1'b0;
                    output_comp_pin[o] <= 1'b1;
                end
                else if (clk_en)
                begin
                    if (cfg_single_ended[o])
                    begin
                        output_true_pin[o] <= lvl ^ cfg_inv_true[o];
                        output_comp_pin[o] <= lvl ^ cfg_inv_comp[o];
                    end
                    else
                    begin
                        output_true_pin[o] <= lvl;
                        output_comp_pin[o] <= ~lvl;
                    end
                end
            end

            // code 1 unavailable on low supply; code 0 is not a code
            assign drv = cfg_drive_select[o*`OCGC_DRV_W +: `OCGC_DRV_W];
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    single_ended_drive_select[o*`OCGC_DRV_W +: `OCGC_DRV_W] <= `OCGC_DRV_THREE;
                else if (clk_en)
                begin
                    if (drv == 2'h0 || (drv == `OCGC_DRV_ONE && cfg_vddo_low[o]))
                        single_ended_drive_select[o*`OCGC_DRV_W +: `OCGC_DRV_W] <= `OCGC_DRV_TWO;
                    else
                        single_ended_drive_select[o*`OCGC_DRV_W +: `OCGC_DRV_W] <= drv;
                end
            end

            // unused drivers off by configuration
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    driver_power_down[o] <= 1'b0;
                else if (clk_en)
                    driver_power_down[o] <= cfg_driver_pd[o];
            end

            assign out_enabled[o] = en_r;
        end
    endgenerate

endmodule : ocgc_top

// ### rtl/ocgc_consts.svh
// constants for the output clock gating control block
`ifndef OCGC_CONSTS_SVH
`define OCGC_CONSTS_SVH

`define OCGC_NUM_OUT       12
`define OCGC_NUM_DIV       4
`define OCGC_SEL_W         2
`define OCGC_DIV_W         8
`define OCGC_DRV_W         2
`define OCGC_STORE_W       24
`define OCGC_STORE_MAX     2'h2
`define OCGC_STORE_DEF     24'h000000
`define OCGC_INIT_NS       100
`define OCGC_CLK_NS        10
`define OCGC_INIT_CYC      ((`OCGC_INIT_NS + `OCGC_CLK_NS - 1) / `OCGC_CLK_NS)
`define OCGC_CNT_W         4
`define OCGC_DRV_ONE       2'h1
`define OCGC_DRV_TWO       2'h2
`define OCGC_DRV_THREE     2'h3

`endif

// ### rtl/ocgc_pkg.sv
// types for the output clock gating control block
package ocgc_pkg;

    // sequencing of the block after reset
    typedef enum logic [0:0] {
        OCGC_ST_INIT = 1'b0,
        OCGC_ST_RUN  = 1'b1
    } ocgc_state_t;

endpackage : ocgc_pkg

// ### bench/ocgc_top_asserts.sv
// concurrent checks on the ports of ocgc_top
`timescale 1ns/1ps

module ocgc_top_asserts
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        global_output_disable_pin,
    input wire logic        power_down_pin_n,
    input wire logic        three_wire_select,
    input wire logic [11:0] cfg_single_ended,
    input wire logic [11:0] cfg_inv_true,
    input wire logic [11:0] cfg_inv_comp,
    input wire logic [11:0] cfg_sync_gate,
    input wire logic        cfg_wr,
    input wire logic [11:0] cfg_out_disable,
    input wire logic [11:0] cfg_disable_high,
    input wire logic        store_program,
    input wire logic [11:0] output_true_pin,
    input wire logic [11:0] output_comp_pin,
    input wire logic [11:0] out_enabled,
    input wire logic [11:0] out_disable_r_q,
    input wire logic [11:0] disable_high_q,
    input wire logic        init_done,
    input wire logic [1:0]  store_write_count,
    input wire logic        serial_is_i2c,
    input wire logic        spi_shared_data
);
    // ----
    // clocking and steps
    // ----
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // pin held long enough to cross the two-flop synchroniser
    sequence s_glob_hold;
        (global_output_disable_pin && power_down_pin_n && !cfg_sync_gate[11])[*5];
    endsequence
    // init window is never shorter than this
    sequence s_init_quiet;
        !init_done[*8];
    endsequence

    // ----
    // checks
    // ----
    a_glob_off: assert property (s_glob_hold |-> !out_enabled[11])
        else $error("global disable did not gate output");
    a_diff_comp: assert property ($past(rst_n) && !$past(cfg_single_ended[0]) |->
        output_comp_pin[0] != output_true_pin[0])
        else $error("differential pins not complementary");
    a_se_phase: assert property ($past(rst_n) && $past(cfg_single_ended[0]) |->
        output_comp_pin[0] == (output_true_pin[0] ^ $past(cfg_inv_true[0]) ^ $past(cfg_inv_comp[0])))
        else $error("single ended polarity wrong");
    a_dis_level: assert property ($past(rst_n) && !$past(out_enabled[0]) && !$past(cfg_single_ended[0]) |->
        output_true_pin[0] == $past(disable_high_q[0]))
        else $error("disabled level wrong");
    a_reg_load: assert property (cfg_wr && init_done |=>
        out_disable_r_q == $past(cfg_out_disable) && disable_high_q == $past(cfg_disable_high))
        else $error("working registers not loaded");
    a_store_inc: assert property (store_program && init_done && store_write_count != 2'h2 |=>
        store_write_count == $past(store_write_count) + 2'h1)
        else $error("store count did not step");
    a_store_sat: assert property (store_write_count == 2'h2 |=> store_write_count == 2'h2)
        else $error("store count left saturation");
    a_init_hold: assert property ($fell(init_done) |-> s_init_quiet)
        else $error("init window too short");
    a_spi_shared: assert property (spi_shared_data == (!serial_is_i2c && three_wire_select))
        else $error("shared data mode wrong");
endmodule : ocgc_top_asserts

bind ocgc_top ocgc_top_asserts u_chk (.*);

// ### bench/ocgc_clk_rx.sv
// downstream clock receiver that counts shortened pulses
`timescale 1ns/1ps

module ocgc_clk_rx
#(
    parameter int MIN_RUN = 4
)
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic clk_pin,
    output int        runt_cnt
);
    logic last_r; // level seen last cycle
    int   run_r;  // cycles at that level
    logic seen_r; // first run is partial, skip it

    // ----
    // run length monitor
    // ----
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_r   <= 1'b0;
            run_r    <= 0;
            seen_r   <= 1'b0;
            runt_cnt <= 0;
        end
        else if (clk_pin != last_r)
        begin
            // static levels merge into runs, so only cut halves count
            if (seen_r && run_r < MIN_RUN)
                runt_cnt <= runt_cnt + 1;
            last_r <= clk_pin;
            run_r  <= 1;
            seen_r <= 1'b1;
        end
        else
            run_r <= run_r + 1;
    end
endmodule : ocgc_clk_rx

// ### bench/output_clock_gating_control_tb_top.sv
// self-checking bench for the output clock gating control block
`timescale 1ns/1ps

module output_clock_gating_control_tb_top;
    // ----
    // signals
    // ----
    logic        ref_clk, rst_n, clk_en, global_output_disable_pin, power_down_pin_n;
    logic        device_reset_pin_n, lock_loss, crystal_ref_loss_alarm, i2c_select_pin;
    logic        three_wire_select, cfg_soft_reset, cfg_lol_disable, cfg_xtal_keep_on;
    logic        cfg_wr, store_program, init_done, serial_is_i2c, spi_shared_data;
    logic [31:0] cfg_div_half;
    logic [23:0] cfg_out_src, cfg_drive_select, single_ended_drive_select;
    logic [11:0] cfg_single_ended, cfg_inv_true, cfg_inv_comp, cfg_vddo_low, cfg_sync_gate;
    logic [11:0] cfg_driver_pd, cfg_out_disable, cfg_disable_high, output_true_pin;
    logic [11:0] output_comp_pin, driver_power_down, out_enabled, out_disable_r_q, disable_high_q;
    logic [1:0]  store_write_count;
    int          miscompares = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          runt_cnt;
    int          per_exp [4] = '{8, 4, 6, 2}; // divider periods from half values 3,1,2,0

    ocgc_top u_dut (.*);
    ocgc_clk_rx #(.MIN_RUN(4)) u_rx (.ref_clk(ref_clk), .rst_n(rst_n), .clk_pin(output_true_pin[0]),
        .runt_cnt(runt_cnt));

    // 100 MHz clock and a hang guard
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            miscompares++;
            conclude();
        end
    end

    // ----
    // helpers
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // wait n edges, then sample where values are settled
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : settle
    task automatic wr(input logic [11:0] dis, input logic [11:0] hi);
        @(posedge ref_clk);
        cfg_wr           <= 1'b1;
        cfg_out_disable  <= dis;
        cfg_disable_high <= hi;
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
    endtask : wr
    task automatic wait_init();
        int n;
        n = 0;
        while (init_done !== 1'b1 && n < 60)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk(init_done, 1'b1);
    endtask : wait_init
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // ----
    // scenarios
    // ----
    task automatic t_init();
        wait_init();
        chk(out_disable_r_q, 12'h000);
        chk(store_write_count, 2'h0);
        settle(12);
        chk(out_enabled, 12'hfff);
    endtask : t_init
    // each output measured against the divider it is routed to
    task automatic t_route();
        time t0;
        for (int k = 0; k < 12; k++)
        begin
            @(posedge output_true_pin[k]);
            t0 = $time;
            @(posedge output_true_pin[k]);
            chk(32'(($time - t0) / 10), per_exp[k % 4]);
            @(negedge ref_clk);
            chk(output_comp_pin[k], !output_true_pin[k]);
        end
    endtask : t_route
    task automatic t_global();
        wr(12'h000, 12'h5a4);
        @(posedge ref_clk);
        global_output_disable_pin <= 1'b1;
        settle(16);
        chk(out_enabled, 12'h000);
        chk(output_true_pin, 12'h5a4);
        chk(output_comp_pin, 12'ha5b);
        wr(12'h0a5, 12'h000);
        @(posedge ref_clk);
        global_output_disable_pin <= 1'b0;
        settle(16);
        chk(out_disable_r_q, 12'h0a5);
        chk(out_enabled, 12'hf5a);
        wr(12'h000, 12'h000);
    endtask : t_global
    // lock loss and crystal alarm, with and without their options
    task automatic t_faults();
        logic [3:0] cs [4] = '{4'b1000, 4'b1100, 4'b0010, 4'b0011};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge ref_clk);
            {lock_loss, cfg_lol_disable, crystal_ref_loss_alarm, cfg_xtal_keep_on} <= cs[i];
            settle(16);
            chk(out_enabled, (i == 0 || i == 3) ? 12'hfff : 12'h000);
            @(posedge ref_clk);
            {lock_loss, cfg_lol_disable, crystal_ref_loss_alarm, cfg_xtal_keep_on} <= 4'h0;
            settle(16);
        end
    endtask : t_faults
    // output 1 gates at once, output 0 waits for its period end
    task automatic t_gate();
        wr(12'h003, 12'h000);
        settle(1);
        chk(out_enabled[1], 1'b0);
        settle(10);
        chk(out_enabled[0], 1'b0);
        for (int j = 0; j < 8; j++)
        begin
            wr(12'h000, 12'h000);
            settle(j);
            wr(12'h001, 12'h000);
            settle(j + 3);
        end
        wr(12'h000, 12'h000);
        settle(16);
        chk(runt_cnt, 0);
    endtask : t_gate
    task automatic t_pd();
        wr(12'h800, 12'h000);
        @(posedge ref_clk);
        power_down_pin_n <= 1'b0;
        settle(20);
        chk(out_enabled, 12'h000);
        chk(out_disable_r_q, 12'h800);
        for (int s = 0; s < 4; s++)
        begin
            @(posedge ref_clk);
            {i2c_select_pin, three_wire_select} <= s[1:0];
            settle(4);
            chk(serial_is_i2c, s[1]);
            chk(spi_shared_data, !s[1] && s[0]);
        end
        @(posedge ref_clk);
        power_down_pin_n <= 1'b1;
        settle(20);
        chk(out_enabled, 12'h7ff);
        chk(runt_cnt, 0);
        wr(12'h000, 12'h000);
    endtask : t_pd
    task automatic t_drive();
        logic [1:0] e;
        for (int m = 0; m < 4; m++)
        begin
            @(posedge ref_clk);
            cfg_single_ended <= 12'hfff;
            cfg_inv_true     <= {12{m[0]}};
            cfg_inv_comp     <= {12{m[1]}};
            settle(3);
            chk(output_true_pin ^ output_comp_pin, {12{m[0] ^ m[1]}});
        end
        for (int c = 0; c < 8; c++)
        begin
            @(posedge ref_clk);
            cfg_drive_select <= {12{c[1:0]}};
            cfg_vddo_low     <= {12{c[2]}};
            e = (c[1:0] == 2'h0 || (c[1:0] == 2'h1 && c[2])) ? 2'h2 : c[1:0];
            settle(2);
            chk(single_ended_drive_select, {12{e}});
        end
        @(posedge ref_clk);
        cfg_driver_pd <= 12'h3c3;
        settle(2);
        chk(driver_power_down, 12'h3c3);
    endtask : t_drive
    // third program refused; resets reload the newest image
    task automatic t_store();
        for (int j = 0; j < 3; j++)
        begin
            wr(12'(12'h111 + 12'h222 * j), 12'(12'h222 * (j + 1)));
            @(posedge ref_clk);
            store_program <= 1'b1;
            @(posedge ref_clk);
            store_program <= 1'b0;
            settle(1);
            chk(store_write_count, (j < 2) ? j + 1 : 2);
        end
        wr(12'h000, 12'h000);
        @(posedge ref_clk);
        device_reset_pin_n <= 1'b0;
        settle(4);
        chk(init_done, 1'b0);
        @(posedge ref_clk);
        device_reset_pin_n <= 1'b1;
        wait_init();
        chk({disable_high_q, out_disable_r_q}, 24'h444333);
        wr(12'h000, 12'h000);
        @(posedge ref_clk);
        cfg_soft_reset <= 1'b1;
        @(posedge ref_clk);
        cfg_soft_reset <= 1'b0;
        settle(2);
        chk(init_done, 1'b0);
        wait_init();
        chk(out_disable_r_q, 12'h333);
    endtask : t_store

    // ----
    // main sequence
    // ----
    initial
    begin
        rst_n = 1'b0;
        {clk_en, power_down_pin_n, device_reset_pin_n} = 3'h7;
        {global_output_disable_pin, lock_loss, crystal_ref_loss_alarm, i2c_select_pin} = 4'h0;
        {three_wire_select, cfg_soft_reset, cfg_lol_disable, cfg_xtal_keep_on} = 4'h0;
        {cfg_wr, store_program} = 2'h0;
        cfg_div_half = 32'h00020103;
        cfg_out_src = 24'he4e4e4;
        {cfg_single_ended, cfg_inv_true, cfg_inv_comp, cfg_vddo_low} = 48'h0;
        {cfg_driver_pd, cfg_out_disable, cfg_disable_high} = 36'h0;
        cfg_drive_select = 24'h000000;
        cfg_sync_gate = 12'h001;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_init();
        t_route();
        t_global();
        t_faults();
        t_gate();
        t_pd();
        t_drive();
        t_store();
        conclude();
    end
endmodule : output_clock_gating_control_tb_top
